// ==== hdl/smrd_pkg.sv ====
// Shared constants for the mode-register decode block
package smrd_pkg;
  localparam int          MR_W         = 22;
  localparam int          SEL_LO       = 18;
  localparam int          SEL_HI       = 20;
  localparam logic [2:0]  SEL_TIMING   = 3'h0;
  localparam logic [2:0]  SEL_IO_TERM  = 3'h1;
  localparam logic [2:0]  SEL_DO_NOT_USE = 3'h7;
  localparam int          TIM_TEST     = 7;
  localparam int          TIM_DLL_RST  = 8;
  localparam int          IOT_QOFF     = 12;
  localparam int          IOT_XSTRB    = 11;
  localparam int          IOT_TERM_HI  = 10;
  localparam int          IOT_TERM_LO  = 8;
  localparam int          IOT_WLEV     = 7;
  localparam int          IOT_EQ_TOP   = 13;
  localparam int          IOT_EQ_HI    = 6;
  localparam int          IOT_EQ_LO    = 5;
  localparam int          IOT_ADDLAT_HI = 4;
  localparam int          IOT_ADDLAT_LO = 3;
  localparam int          IOT_DRV_HI   = 2;
  localparam int          IOT_DRV_LO   = 1;
  localparam int          IOT_DLL_EN   = 0;
  localparam logic [21:0] TIM_RST      = 22'h000000;
  localparam logic [21:0] IOT_RST      = 22'h000000;
  localparam logic        X8_CONFIG    = 1'b1;
  localparam int          DLY_DEPTH    = 63;
  localparam int          DLL_LOCK_CYC = 768;

  typedef enum logic [1:0] {
    SMRD_ADDLAT_ZERO = 2'b00,
    SMRD_ADDLAT_M1   = 2'b01,
    SMRD_ADDLAT_M2   = 2'b10,
    SMRD_ADDLAT_RSVD = 2'b11
  } smrd_addlat_e;

  typedef enum logic [1:0] {
    SMRD_DLL_OFF     = 2'b00,
    SMRD_DLL_LOCKING = 2'b01,
    SMRD_DLL_LOCKED  = 2'b10
  } smrd_dll_e;

  // Nominal termination in ohms, zero when off
  function automatic logic [7:0] term_ohms(input logic [2:0] c);
    logic [7:0] r;
    r = 8'h00;
    unique case (c)
      3'h0: r = 8'h00;
      3'h1: r = 8'h3c;
      3'h2: r = 8'h78;
      3'h3: r = 8'h28;
      3'h4: r = 8'hf0;
      3'h5: r = 8'h30;
      3'h6: r = 8'h50;
      3'h7: r = 8'h22;
    endcase
    return r;
  endfunction : term_ohms

  // Driver impedance in ohms, zero for the unusable code
  function automatic logic [7:0] drv_ohms(input logic [1:0] c);
    logic [7:0] r;
    r = 8'h00;
    unique case (c)
      2'h0: r = 8'h22;
      2'h1: r = 8'h30;
      2'h2: r = 8'h28;
      2'h3: r = 8'h00;
    endcase
    return r;
  endfunction : drv_ohms
endpackage : smrd_pkg

// ==== hdl/smrd_mrs_if.sv ====
// Decoded mode register set command between decoder and core
`timescale 1ns/10ps
`default_nettype none
interface smrd_mrs_if;
  logic        hit;
  logic [2:0]  sel;
  logic [21:0] word;
  modport dec  (output hit, sel, word);
  modport core (input hit, sel, word);
endinterface : smrd_mrs_if
`default_nettype wire

// ==== hdl/smrd_pulse_delay.sv ====
// Programmable pulse delay line
`timescale 1ns/10ps
`default_nettype none
module smrd_pulse_delay (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Pulse and delay in cycles
  input  wire logic       pulse_in,
  input  wire logic [5:0] dly,
  output logic            pulse_out
);
  logic [smrd_pkg::DLY_DEPTH-1:0] sr;

  always_ff @(posedge clk) begin
    if (srst) begin
      sr <= '0;
    end else begin
      sr <= {sr[smrd_pkg::DLY_DEPTH-2:0], pulse_in};
    end
  end

  assign pulse_out = (dly == 6'h00) ? pulse_in : sr[dly - 6'h01];
endmodule : smrd_pulse_delay
`default_nettype wire

// ==== hdl/smrd_mrs_decode.sv ====
// Pin decode of mode register set commands
`timescale 1ns/10ps
`default_nettype none
module smrd_mrs_decode (
  // Command pins
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bg,
  input  wire logic [1:0]  ba,
  input  wire logic        a17,
  input  wire logic [13:0] a,
  // Decoded command
  smrd_mrs_if.dec          mrs
);
  wire       is_mrs;
  wire [2:0] sel;

  assign is_mrs   = !cs_n && !ras_n && !cas_n && !we_n; // [R11]
  assign mrs.word = {bg, ba, a17, 3'h0, a};              // [R11]
  assign sel      = mrs.word[smrd_pkg::SEL_HI:smrd_pkg::SEL_LO];
  assign mrs.sel  = sel;
  // Reserved select code is dropped
  assign mrs.hit  = is_mrs && (sel != smrd_pkg::SEL_DO_NOT_USE); // [R12]
endmodule : smrd_mrs_decode
`default_nettype wire

// ==== hdl/smrd_top.sv ====
// Mode register decode and latency timing core
// Function
// R1: First read data comes whole column-latency cycles after internal read.
// R2: Total read latency is added latency plus column latency.
// R3: Controller keeps test-mode bit zero; one gives undefined test mode. The controller model still writes one when test_ok is set.
// R4: Controller programs write recovery at least recovery time over clock, rounded up.
// R5: Write recovery cycles plus precharge period time write auto-precharge.
// R6: With mask and CRC on, bad CRC cancels the write.
// R7: Controller programs read-to-precharge at least minimum time over clock, rounded up.
// R8: Read-to-precharge plus precharge period time activate after read auto-precharge.
// R9: DLL reset bit clears itself after the reset action.
// R10: Controller resets DLL after enable and waits lock time before reads.
// R11: Command loads bits from bank-group, bank and address pins; strobes low.
// R12: Bits 20:18 select target register; code 111 unused.
// R13: Controller writes zero to reserved bits 21 and 17.
// R14: Output disable bit removes driver impedance and termination.
// R15: Bit 11 enables extra termination strobes, eight-bit configuration only.
// R16: Bits 10:8 select nominal termination value in ohms.
// R17: Bit 7 enters write leveling mode.
// R18: Bits 13,6,5 select receiver equalizer setting.
// R19: Bits 4:3 set added latency: zero, minus one, minus two, reserved.
// R20: Controller avoids minus-one added latency under quarter-rate gear-down.
// R21: Bits 2:1 set driver impedance 34, 48, 40 ohms or reserved.
// R22: Bit 0 enables the DLL.
// R23: Reads wait internally for the added latency before executing.
// R24: Second register changes only on commands selecting code 001.
`timescale 1ns/10ps
`default_nettype none
module smrd_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Command pins
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bg,
  input  wire logic [1:0]  ba,
  input  wire logic        a17,
  input  wire logic [13:0] a,
  // Timing settings in cycles
  input  wire logic [4:0]  col_latency,
  input  wire logic [4:0]  wr_recovery,
  input  wire logic [3:0]  rd_pre_cycles,
  input  wire logic [4:0]  precharge_cycles,
  // Array commands
  input  wire logic        rd_cmd,
  input  wire logic        rd_ap_cmd,
  input  wire logic        wr_ap_cmd,
  input  wire logic        wr_data_done,
  input  wire logic        crc_error,
  input  wire logic        data_mask_en,
  input  wire logic        write_crc_en,
  // Decoded settings
  output logic             out_disable,
  output logic             xstrb_en,
  output logic [7:0]       nominal_termination_ohms,
  output logic             write_level,
  output logic [2:0]       rx_eq,
  output logic [4:0]       addlat_cycles,
  output logic [7:0]       drv_ohms,
  output logic             dll_enable,
  output logic             test_mode,
  // DLL status
  output logic             dll_reset_pulse,
  output logic             dll_locked,
  // Timing events
  output logic             int_rd,
  output logic             rd_data_start,
  output logic             int_pre,
  output logic             wr_ap_done,
  output logic             act_ok,
  output logic             wr_commit,
  output logic             wr_discard
);
  smrd_mrs_if mrs ();

  smrd_mrs_decode u_dec (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .bg    (bg),
    .ba    (ba),
    .a17   (a17),
    .a     (a),
    .mrs   (mrs)
  );

  logic [21:0]         timing_mode_register;
  logic [21:0]         io_and_termination_mode;
  smrd_pkg::smrd_dll_e dll_state;
  logic [9:0]          lock_cnt;

  wire        load0;
  wire        load1;
  wire        dll_rst_bit;
  wire [1:0]  addlat_code;
  wire [4:0]  added_command_latency;
  wire [5:0]  total_read_latency;
  wire [5:0]  autoprecharge_write_delay;
  wire [5:0]  act_delay;
  wire [5:0]  wr_dly;
  wire        qoff;
  wire        crc_check;
  wire        d_int_rd;
  wire        d_rd_data;
  wire        d_int_pre;
  wire        d_wr_done;
  wire        d_act_ok;
  wire        lock_done;

  assign load0 = mrs.hit && (mrs.sel == smrd_pkg::SEL_TIMING);  // [R12]
  assign load1 = mrs.hit && (mrs.sel == smrd_pkg::SEL_IO_TERM); // [R24]
  assign dll_rst_bit = timing_mode_register[smrd_pkg::TIM_DLL_RST];
  assign qoff  = io_and_termination_mode[smrd_pkg::IOT_QOFF];
  assign addlat_code = io_and_termination_mode[smrd_pkg::IOT_ADDLAT_HI:smrd_pkg::IOT_ADDLAT_LO];

  // Reserved added latency code behaves as zero
  assign added_command_latency =
    (addlat_code == smrd_pkg::SMRD_ADDLAT_M1 && col_latency >= 5'h01) ? col_latency - 5'h01 :
    (addlat_code == smrd_pkg::SMRD_ADDLAT_M2 && col_latency >= 5'h02) ? col_latency - 5'h02 :
    5'h00; // [R19]
  assign total_read_latency = {1'b0, added_command_latency} + {1'b0, col_latency}; // [R2]
  assign wr_dly = {1'b0, wr_recovery};
  assign autoprecharge_write_delay = wr_dly + {1'b0, precharge_cycles}; // [R5]
  assign act_delay = {2'h0, rd_pre_cycles} + {1'b0, precharge_cycles}; // [R8]
  assign crc_check = data_mask_en && write_crc_en;
  assign lock_done = (lock_cnt == 10'(smrd_pkg::DLL_LOCK_CYC - 1));

  // Mode registers; the DLL reset bit clears itself, a new load wins
  always_ff @(posedge clk) begin
    if (srst) begin
      timing_mode_register <= smrd_pkg::TIM_RST;
    end else if (load0) begin
      timing_mode_register <= mrs.word; // [R11]
    end else begin
      timing_mode_register[smrd_pkg::TIM_DLL_RST] <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      io_and_termination_mode <= smrd_pkg::IOT_RST;
    end else if (load1) begin
      io_and_termination_mode <= mrs.word; // [R24]
    end
  end

  // DLL lock tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      dll_state <= smrd_pkg::SMRD_DLL_OFF;
      lock_cnt  <= 10'h000;
    end else begin
      unique case (dll_state)
        smrd_pkg::SMRD_DLL_OFF: begin
          lock_cnt <= 10'h000;
          if (dll_enable && dll_reset_pulse) begin
            dll_state <= smrd_pkg::SMRD_DLL_LOCKING;
          end
        end
        smrd_pkg::SMRD_DLL_LOCKING: begin
          lock_cnt <= lock_cnt + 10'h001;
          if (!dll_enable) begin
            dll_state <= smrd_pkg::SMRD_DLL_OFF;
          end else if (lock_done) begin
            dll_state <= smrd_pkg::SMRD_DLL_LOCKED;
          end
        end
        smrd_pkg::SMRD_DLL_LOCKED: begin
          lock_cnt <= 10'h000;
          if (!dll_enable) begin
            dll_state <= smrd_pkg::SMRD_DLL_OFF;
          end else if (dll_reset_pulse) begin
            dll_state <= smrd_pkg::SMRD_DLL_LOCKING;
          end
        end
        default: begin
          dll_state <= smrd_pkg::SMRD_DLL_OFF;
        end
      endcase
    end
  end

  // Field decode to pin-facing flops
  always_ff @(posedge clk) begin
    if (srst) begin
      out_disable  <= 1'b0;
      xstrb_en     <= 1'b0;
      nominal_termination_ohms <= 8'h00;
      write_level  <= 1'b0;
      rx_eq        <= 3'h0;
      addlat_cycles <= 5'h00;
      drv_ohms     <= 8'h00;
      dll_enable   <= 1'b0;
      test_mode    <= 1'b0;
    end else begin
      out_disable  <= qoff; // [R14]
      xstrb_en     <= smrd_pkg::X8_CONFIG
                      && io_and_termination_mode[smrd_pkg::IOT_XSTRB]; // [R15]
      nominal_termination_ohms <= qoff ? 8'h00 : smrd_pkg::term_ohms(
        io_and_termination_mode[smrd_pkg::IOT_TERM_HI:smrd_pkg::IOT_TERM_LO]); // [R16]
      write_level  <= io_and_termination_mode[smrd_pkg::IOT_WLEV]; // [R17]
      rx_eq        <= {io_and_termination_mode[smrd_pkg::IOT_EQ_TOP],
                       io_and_termination_mode[smrd_pkg::IOT_EQ_HI:smrd_pkg::IOT_EQ_LO]}; // [R18]
      addlat_cycles <= added_command_latency; // [R19]
      drv_ohms     <= qoff ? 8'h00 : smrd_pkg::drv_ohms(
        io_and_termination_mode[smrd_pkg::IOT_DRV_HI:smrd_pkg::IOT_DRV_LO]); // [R21]
      dll_enable   <= io_and_termination_mode[smrd_pkg::IOT_DLL_EN]; // [R22]
      test_mode    <= timing_mode_register[smrd_pkg::TIM_TEST]; // [R3]
    end
  end

  // Delay lines for read, write and precharge timing
  smrd_pulse_delay u_int_rd (
    .clk       (clk),
    .srst      (srst),
    .pulse_in  (rd_cmd),
    .dly       ({1'b0, added_command_latency}),
    .pulse_out (d_int_rd)
  ); // [R23]

  smrd_pulse_delay u_rd_data (
    .clk       (clk),
    .srst      (srst),
    .pulse_in  (rd_cmd),
    .dly       (total_read_latency),
    .pulse_out (d_rd_data)
  ); // [R1]

  smrd_pulse_delay u_int_pre (
    .clk       (clk),
    .srst      (srst),
    .pulse_in  (wr_ap_cmd),
    .dly       (wr_dly),
    .pulse_out (d_int_pre)
  );

  smrd_pulse_delay u_wr_done (
    .clk       (clk),
    .srst      (srst),
    .pulse_in  (wr_ap_cmd),
    .dly       (autoprecharge_write_delay),
    .pulse_out (d_wr_done)
  ); // [R5]

  smrd_pulse_delay u_act_ok (
    .clk       (clk),
    .srst      (srst),
    .pulse_in  (rd_ap_cmd),
    .dly       (act_delay),
    .pulse_out (d_act_ok)
  ); // [R8]

  // Event flops and write commit decision
  always_ff @(posedge clk) begin
    if (srst) begin
      dll_reset_pulse <= 1'b0;
      dll_locked      <= 1'b0;
      int_rd          <= 1'b0;
      rd_data_start   <= 1'b0;
      int_pre         <= 1'b0;
      wr_ap_done      <= 1'b0;
      act_ok          <= 1'b0;
      wr_commit       <= 1'b0;
      wr_discard      <= 1'b0;
    end else begin
      dll_reset_pulse <= dll_rst_bit; // [R9]
      dll_locked      <= (dll_state == smrd_pkg::SMRD_DLL_LOCKED) && dll_enable; // [R10]
      int_rd          <= d_int_rd;
      rd_data_start   <= d_rd_data;
      int_pre         <= d_int_pre;
      wr_ap_done      <= d_wr_done;
      act_ok          <= d_act_ok;
      wr_commit       <= wr_data_done && !(crc_check && crc_error); // [R6]
      wr_discard      <= wr_data_done && crc_check && crc_error;    // [R6]
    end
  end

  property p_iot_hold;
    @(posedge clk) disable iff (srst)
      !load1 |=> $stable(io_and_termination_mode);
  endproperty
  a_iot_hold: assert property (p_iot_hold) else $error("second register changed"); // [R24]

  property p_iot_load;
    @(posedge clk) disable iff (srst)
      load1 |=> io_and_termination_mode == $past(mrs.word);
  endproperty
  a_iot_load: assert property (p_iot_load) else $error("second register not loaded"); // [R11]

  property p_dll_selfclr;
    @(posedge clk) disable iff (srst)
      dll_rst_bit && !load0 |=> !dll_rst_bit ##1 !dll_reset_pulse;
  endproperty
  a_dll_selfclr: assert property (p_dll_selfclr) else $error("dll reset bit stuck"); // [R9]

  property p_qoff;
    @(posedge clk) disable iff (srst)
      qoff |=> nominal_termination_ohms == 8'h00 && drv_ohms == 8'h00 && out_disable;
  endproperty
  a_qoff: assert property (p_qoff) else $error("outputs not disabled"); // [R14]

  property p_rtt34;
    @(posedge clk) disable iff (srst)
      !qoff && io_and_termination_mode[10:8] == 3'h7 |=> nominal_termination_ohms == 8'h22;
  endproperty
  a_rtt34: assert property (p_rtt34) else $error("termination code wrong"); // [R16]

  property p_addlat_minus1;
    @(posedge clk) disable iff (srst)
      addlat_code == 2'b01 && col_latency >= 5'h01 |=> addlat_cycles == $past(col_latency) - 5'h01;
  endproperty
  a_addlat_minus1: assert property (p_addlat_minus1) else $error("added latency wrong"); // [R19]

  property p_crc_block;
    @(posedge clk) disable iff (srst)
      wr_data_done && data_mask_en && write_crc_en && crc_error |=> wr_discard && !wr_commit;
  endproperty
  a_crc_block: assert property (p_crc_block) else $error("bad write committed"); // [R6]

  property p_rl10;
    @(posedge clk) disable iff (srst)
      rd_cmd && total_read_latency == 6'h0a && $stable(total_read_latency)
        |-> ##11 rd_data_start;
  endproperty
  a_rl10: assert property (p_rl10) else $error("read data late or early"); // [R2]

  property p_drv40;
    @(posedge clk) disable iff (srst)
      !qoff && io_and_termination_mode[2:1] == 2'h2 |=> drv_ohms == 8'h28;
  endproperty
  a_drv40: assert property (p_drv40) else $error("driver impedance wrong"); // [R21]
endmodule : smrd_top
`default_nettype wire

// ==== sim/smrd_ctrl_model.sv ====
// Controller model issuing mode register set commands
`timescale 1ns/10ps
`default_nettype none
module smrd_ctrl_model (
  // Clock
  input  wire logic        clk,
  // Command pins
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [1:0]       bg,
  output logic [1:0]       ba,
  output logic             a17,
  output logic [13:0]      a
);
  // Quarter-rate gear-down stays off on this link
  localparam logic GEAR_DOWN = 1'b0;
  logic [21:0] last;

  initial begin
    last = 22'h000000;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {bg, ba, a17, a} = 19'h7ffff;
  end

  // One command cycle, then idle with pins flipped
  task automatic mrs(input logic [21:0] w, input logic test_ok);
    @(negedge clk);
    last = w & ~22'h220000;
    if (!test_ok && last[20:18] == 3'h0) last[7] = 1'h0;
    if (GEAR_DOWN && last[20:18] == 3'h1 && last[4:3] == 2'h1) last[4:3] = 2'h0;
    {bg, ba, a17, a} = {last[21:17], last[13:0]};
    {cs_n, ras_n, cas_n, we_n} = 4'h0;
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {bg, ba, a17, a} = ~{last[21:17], last[13:0]};
  endtask : mrs
endmodule : smrd_ctrl_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the mode register decode block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        cs_n, ras_n, cas_n, we_n, a17;
  logic [1:0]  bg, ba;
  logic [13:0] a;
  logic [4:0]  col_latency = 5'h0a;
  logic [4:0]  wr_recovery = 5'h01;
  logic [4:0]  precharge_cycles = 5'h01;
  logic [3:0]  rd_pre_cycles = 4'h1;
  logic        rd_cmd = 1'h0, rd_ap_cmd = 1'h0, wr_ap_cmd = 1'h0, wr_data_done = 1'h0;
  logic        crc_error = 1'h0, data_mask_en = 1'h0, write_crc_en = 1'h0;
  wire  [28:0] got;
  logic [28:0] cur = 29'h0;
  wire  [7:0]  ev;
  logic [7:0]  rtt_t [8] = '{8'h00, 8'h3c, 8'h78, 8'h28, 8'hf0, 8'h30, 8'h50, 8'h22};
  logic [7:0]  drv_t [4] = '{8'h22, 8'h30, 8'h28, 8'h00};
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          exp_q [9][$];

  smrd_ctrl_model i_smrd_ctrl_model (.clk, .cs_n, .ras_n, .cas_n, .we_n, .bg, .ba, .a17, .a);

  smrd_top i_smrd_top (
    .clk, .srst, .cs_n, .ras_n, .cas_n, .we_n, .bg, .ba, .a17, .a,
    .col_latency, .wr_recovery, .rd_pre_cycles, .precharge_cycles,
    .rd_cmd, .rd_ap_cmd, .wr_ap_cmd, .wr_data_done, .crc_error, .data_mask_en, .write_crc_en,
    .out_disable(got[28]), .xstrb_en(got[27]), .nominal_termination_ohms(got[26:19]),
    .write_level(got[18]), .rx_eq(got[17:15]), .addlat_cycles(got[14:10]),
    .drv_ohms(got[9:2]), .dll_enable(got[1]), .test_mode(got[0]),
    .dll_reset_pulse(ev[7]), .dll_locked(),
    .int_rd(ev[0]), .rd_data_start(ev[1]), .int_pre(ev[2]), .wr_ap_done(ev[3]),
    .act_ok(ev[4]), .wr_commit(ev[5]), .wr_discard(ev[6])
  );

  always #12.5 clk = ~clk;

  always @(posedge clk) cyc <= cyc + 1;

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk_time(input int e, input int lo, input int hi, input int seen);
    tests_run++;
    if (seen < lo || seen > hi) begin
      error_cnt++;
      $display("CHECK FAILED event %0d expected cycle %0d..%0d seen %0d", e, lo, hi, seen);
    end
  endtask : chk_time

  task automatic chk_set(input logic [28:0] expv);
    tests_run++;
    if (got !== expv) begin
      error_cnt++;
      $display("CHECK FAILED settings expected %h seen %h", expv, got);
    end
  endtask : chk_set

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Second register write, then settings compared two cycles on
  task automatic io_write(input logic [21:0] w);
    logic [4:0] add_lat;
    w[21:17] = 5'h02;
    add_lat = (w[4:3] == 2'h1) ? col_latency - 5'h01 :
              (w[4:3] == 2'h2) ? col_latency - 5'h02 : 5'h00;
    // Output disable removes both termination and driver impedance
    cur = {w[12], smrd_pkg::X8_CONFIG & w[11], w[12] ? 8'h00 : rtt_t[w[10:8]], w[7], w[13],
           w[6:5], add_lat, w[12] ? 8'h00 : drv_t[w[2:1]], w[0], cur[0]};
    i_smrd_ctrl_model.mrs(w, 1'h0);
    tick(2);
    chk_set(cur);
  endtask : io_write

  // Array command pulses with their expected event cycles
  task automatic fire(input logic [3:0] m);
    int n;
    n = cyc;
    {wr_data_done, wr_ap_cmd, rd_ap_cmd, rd_cmd} = m;
    {crc_error, data_mask_en, write_crc_en} = 3'($urandom);
    if (m[0]) exp_q[0].push_back(n + cur[14:10] + 1);
    if (m[0]) exp_q[1].push_back(n + cur[14:10] + col_latency + 1);
    if (m[2]) exp_q[2].push_back(n + wr_recovery + 1);
    if (m[2]) exp_q[3].push_back(n + wr_recovery + precharge_cycles + 1);
    if (m[1]) exp_q[4].push_back(n + rd_pre_cycles + precharge_cycles + 1);
    if (m[3]) exp_q[(data_mask_en & write_crc_en & crc_error) ? 6 : 5].push_back(n + 1);
    @(negedge clk);
  endtask : fire

  always @(negedge clk) begin
    for (int e = 0; e < 8; e++) begin
      if (ev[e] !== 1'h0) begin
        if (exp_q[e].size() == 0) chk_time(e, -1, -1, cyc);
        else begin
          chk_time(e, exp_q[e][0], exp_q[e][0], cyc);
          void'(exp_q[e].pop_front());
        end
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    logic [21:0] w;
    int          c0;
    int          k;
    void'($urandom(10790));
    repeat (12) @(posedge clk);
    @(negedge clk) srst = 1'h0;
    for (int i = 0; i < 8; i++) begin
      w = 22'($urandom);
      w[10:8] = 3'(i);
      {w[4:3], w[2:1]} = {2'(i), 2'(i)};
      w[12] = (i == 1);
      io_write(w);
    end
    // Selects 010 to 111, the unusable one among them, leave settings alone
    for (int s = 2; s < 8; s++) begin
      w = 22'($urandom);
      w[20:18] = 3'(s);
      i_smrd_ctrl_model.mrs(w, 1'h0);
      tick(2);
      chk_set(cur);
    end
    i_smrd_ctrl_model.mrs(22'h000080, 1'h1);
    tick(2);
    cur[0] = 1'h1;
    chk_set(cur);
    i_smrd_ctrl_model.mrs(22'h000000, 1'h0);
    tick(2);
    cur[0] = 1'h0;
    chk_set(cur);
    w = 22'($urandom);
    w[0] = 1'h1;
    io_write(w);
    exp_q[7].push_back(cyc + 3);
    i_smrd_ctrl_model.mrs(22'h000100, 1'h0);
    c0 = cyc;
    k = 0;
    while (i_smrd_top.dll_locked !== 1'h1 && k < 900) begin
      tick(1);
      k++;
    end
    chk_time(8, c0 + 768, c0 + 773, cyc);
    for (int ac = 0; ac < 4; ac++) begin
      col_latency = (ac == 0) ? 5'h0a : 5'h09 + 5'($urandom_range(15));
      wr_recovery = 5'(($urandom_range(700000, 10000) + 24999) / 25000);
      rd_pre_cycles = 4'(($urandom_range(375000, 5000) + 24999) / 25000);
      precharge_cycles = 5'($urandom_range(20, 1));
      w = 22'($urandom);
      {w[4:3], w[0]} = {2'(ac), 1'h1};
      io_write(w);
      repeat (24) fire(4'($urandom));
      {wr_data_done, wr_ap_cmd, rd_ap_cmd, rd_cmd} = 4'h0;
      tick(70);
    end
    for (int e = 0; e < 8; e++) begin
      if (exp_q[e].size() != 0) chk_time(e, exp_q[e][0], exp_q[e][0], -1);
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
